/* lff_consts.svh */
// Constants for the flash and torch mode controller: offsets, fields, resets, timing.
// Assumes a 100 MHz core clock; included by its bare name.
`ifndef LFF_CONSTS_SVH
`define LFF_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses, one word each)
`define LFF_OFS_TORCH_LVL 8'h00
`define LFF_OFS_FLASH_LVL 8'h04
`define LFF_OFS_FLASH_DUR 8'h08
`define LFF_OFS_CFG1 8'h0C
`define LFF_OFS_CFG2 8'h10
`define LFF_OFS_GPIO 8'h14
`define LFF_OFS_FAULT 8'h18
`define LFF_OFS_STATUS 8'h1C

// ==========================================================================
// Field positions
`define LFF_MODE_HI 1
`define LFF_MODE_LO 0
`define LFF_TORCH_LVL_HI 5
`define LFF_TORCH_LVL_LO 3
`define LFF_IND_LVL_HI 7
`define LFF_IND_LVL_LO 6
`define LFF_FLASH_LVL_HI 6
`define LFF_FLASH_LVL_LO 3
`define LFF_VOUT_BIT 2
`define LFF_PIN_END_BIT 7
`define LFF_DUR_HI 4
`define LFF_DUR_LO 0
`define LFF_CFG1_HWTORCH 7
`define LFF_CFG1_SYNC2_POL 6
`define LFF_CFG1_SYNC2_SEL 5
`define LFF_CFG1_THERM_SEL 3
`define LFF_CFG2_AET 2
`define LFF_CFG2_THERM_SD 1
`define LFF_CFG2_SYNC2_SD 0
`define LFF_GPIO_THERM_EXP 6
`define LFF_GPIO_DATA 5
`define LFF_GPIO_DIR_OUT 4
`define LFF_GPIO_SEL 3
`define LFF_FLT_TIMEOUT 0
`define LFF_FLT_SYNC1 3
`define LFF_FLT_SYNC2 4
`define LFF_FLT_THERM 5

// ==========================================================================
// Reset values
`define LFF_RST_TORCH_LVL 8'h00
`define LFF_RST_FLASH_LVL 8'h00
`define LFF_RST_FLASH_DUR 8'h0F
`define LFF_RST_CFG1 8'h00
`define LFF_RST_CFG2 8'h00
`define LFF_RST_GPIO 8'h00

// ==========================================================================
// Timing
`define LFF_CLK_NS 10
`define LFF_RAMP_STEP_US 16
`define LFF_RAMP_STEP_CYC ((`LFF_RAMP_STEP_US * 1000 + `LFF_CLK_NS - 1) / `LFF_CLK_NS)
`define LFF_TO_STEP_MS 32
`define LFF_TO_STEP_CYC (`LFF_TO_STEP_MS * 1000000 / `LFF_CLK_NS)
`define LFF_DEGLITCH_US 250
`define LFF_DEGLITCH_CYC ((`LFF_DEGLITCH_US * 1000 + `LFF_CLK_NS - 1) / `LFF_CLK_NS)

`endif

/* lff_pkg.sv */
// Types shared by the flash and torch mode controller.
// Assumes nothing of its surroundings.
package lff_pkg;

    // ======================================================================
    // Operating state
    typedef enum logic [1:0] {
        LFF_OFF,
        LFF_TORCH,
        LFF_FLASH,
        LFF_AET_TORCH
    } lff_state_e;

    // ======================================================================
    // Main current source drive
    typedef struct packed {
        logic on;
        logic flash_scale;
        logic [3:0] level;
    } lff_drive_s;

    // Indicator driver drive
    typedef struct packed {
        logic on;
        logic [1:0] level;
    } lff_ind_s;

endpackage : lff_pkg

/* lff_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; one core clock.
`timescale 1ns/1ns
module lff_sync #(
    parameter int W = 4
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, high
    input wire logic [W-1:0] din, // Raw pins
    output logic [W-1:0] dout // Filtered levels
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    // Output changes once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
        end
    end

    assign dout = out_q;
endmodule : lff_sync

/* lff_ramp.sv */
// Stepped current ramp: climbs one level per step time, drops at once.
// Assumes one core clock and a target that holds while valid.
`timescale 1ns/1ns
`include "lff_consts.svh"
module lff_ramp #(
    parameter int STEP_CYCLES = `LFF_RAMP_STEP_CYC
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, high
    input lff_pkg::lff_drive_s target, // Requested drive
    output lff_pkg::lff_drive_s cur // Ramped drive
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    lff_pkg::lff_drive_s cur_q;
    logic [CW-1:0] cnt_q;
    wire restart = target.on && (!cur_q.on || target.flash_scale != cur_q.flash_scale);
    wire climb = target.on && !restart && target.level > cur_q.level;
    wire step_done = cnt_q == CW'(STEP_CYCLES - 1);

    // Restart from level zero on turn-on or scale change, then step up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_q <= '0;
            cnt_q <= '0;
        end else if (!target.on) begin
            cur_q <= '0;
            cnt_q <= '0;
        end else if (restart) begin
            cur_q <= '{on: 1'b1, flash_scale: target.flash_scale, level: 4'h0};
            cnt_q <= '0;
        end else if (climb) begin
            cnt_q <= step_done ? '0 : cnt_q + 1'b1;
            if (step_done) begin
                cur_q.level <= cur_q.level + 4'h1;
            end
        end else begin
            cur_q.level <= target.level;
            cnt_q <= '0;
        end
    end

    assign cur = cur_q;
endmodule : lff_ramp

/* lff_top.sv */
// Flash, torch and indicator mode control with APB register access.
// Assumes a 100 MHz CLOCK; pins are asynchronous and synchronised here.
//
// Summary of operation
// - With pin end select set, pin flash ends only on timeout.
// - With pin end select clear, pin flash ends on trigger low or timeout.
// - Pin end select clear: trigger rising edge restarts the timeout count.
// - Flash end by timeout or trigger low turns both main sources off.
// - Any flash end clears both mode-enable fields to 00.
// - Register flash ends on host writing 00 or timeout clearing enables.
// - Five-bit duration field gives 32 ms to 1024 ms in 32 ms steps.
// - Torch offers eight levels from torch register bits 5:3.
// - Mode pattern 10 in either level register enables torch.
// - Current climbs through each level, 16 us per step.
// - Sync one high during flash gives torch; low restores flash; timeout ends.
// - Hardware torch select: sync one high gives torch; flashes take precedence.
// - Flash started in hardware torch clears the hardware torch select at end.
// - Multi pin forces voltage output, or acts as second sync input.
// - Second sync has selectable polarity; action torch or shutdown.
// - Second sync release: torch ramps back; shutdown waits for fault read.
// - Thermal export drives general pin low until fault read.
// - Indicator runs with thermistor off and pattern 01; four levels.
// - Thermistor mode disables indicator; trip forces torch or shutdown.
// - After thermal torch, flash resumes after fault read and trip gone.
// - Thermal trip passes a 250 us deglitch before acting.
// - Alternate low-light mode: sync before trigger gives torch without timeout.
// - Pattern 11 or trigger rising edge starts flash; level from bits 6:3.
// - Fault register read clears sync change flags and latched faults.
`timescale 1ns/1ns
`include "lff_consts.svh"
module lff_top #(
    parameter int TICK_CYCLES = `LFF_TO_STEP_CYC,
    parameter int DEGLITCH_CYCLES = `LFF_DEGLITCH_CYC,
    parameter int RAMP_CYCLES = `LFF_RAMP_STEP_CYC
) (
    input wire logic CLOCK, // Core clock
    input wire logic RESET, // Async reset, high
    input wire logic [7:0] PADDR, // APB address
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error
    input wire logic STROBE, // Flash trigger pin
    input wire logic RADIO_SYNC_INPUT_ONE, // Sync one or torch pin
    input wire logic GENERAL_IO_TWO_IN, // Multi pin level
    output logic GENERAL_IO_TWO_OUT, // Multi pin drive value
    output logic GENERAL_IO_TWO_OE_N, // Multi pin drive, low drives
    input wire logic THERMISTOR_SENSE_TRIP, // Comparator, high below trip
    output lff_pkg::lff_drive_s MAIN_CURRENT_SOURCE_A, // Source A drive
    output lff_pkg::lff_drive_s MAIN_CURRENT_SOURCE_B, // Source B drive
    output lff_pkg::lff_ind_s INDICATOR_DRIVER, // Indicator drive
    output logic VOLTAGE_OUTPUT_FORCE, // Voltage output mode
    output logic FLASH_ACTIVE // Flash in progress
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int DW = $clog2(DEGLITCH_CYCLES + 1);

    // ======================================================================
    // Pin synchronisers
    logic [3:0] pins_s;
    lff_sync #(.W(4)) u_sync (
        .clk(CLOCK),
        .rst(RESET),
        .din({THERMISTOR_SENSE_TRIP, GENERAL_IO_TWO_IN, RADIO_SYNC_INPUT_ONE, STROBE}),
        .dout(pins_s)
    );
    wire strobe_s = pins_s[0];
    wire sync1_s = pins_s[1];
    wire sync2_s = pins_s[2];
    wire trip_s = pins_s[3];

    // ======================================================================
    // Registers
    logic [7:0] torch_q, torch_d;
    logic [7:0] flash_q, flash_d;
    logic [7:0] dur_q;
    logic [7:0] cfg1_q, cfg1_d;
    logic [7:0] cfg2_q;
    logic [7:0] gpio_q;
    logic [7:0] fault_q, fault_d;
    logic [31:0] prdata_q;
    logic strobe_prev_q, sync1_prev_q, tx2_prev_q;
    logic hwt_at_start_q, pin_flash_q, sd2_q, therm_hold_q, therm_pin_q;
    logic [TW-1:0] presc_q;
    logic [4:0] ticks_q;
    logic [DW-1:0] degl_q;
    lff_pkg::lff_state_e state_q, state_d;

    // APB decode
    wire setup = PSEL && !PENABLE;
    wire access = PSEL && PENABLE;
    wire wr = access && PWRITE;
    wire hit_torch = PADDR == `LFF_OFS_TORCH_LVL;
    wire hit_flash = PADDR == `LFF_OFS_FLASH_LVL;
    wire hit_dur = PADDR == `LFF_OFS_FLASH_DUR;
    wire hit_cfg1 = PADDR == `LFF_OFS_CFG1;
    wire hit_cfg2 = PADDR == `LFF_OFS_CFG2;
    wire hit_gpio = PADDR == `LFF_OFS_GPIO;
    wire hit_fault = PADDR == `LFF_OFS_FAULT;
    wire hit_stat = PADDR == `LFF_OFS_STATUS;
    wire hit = hit_torch | hit_flash | hit_dur | hit_cfg1 | hit_cfg2 | hit_gpio | hit_fault | hit_stat;
    // Clears what setup latched
    wire fault_rd = access && !PWRITE && hit_fault;
    wire [7:0] status = {5'h0, state_q == lff_pkg::LFF_FLASH, pin_flash_q, therm_hold_q};
    wire [7:0] rd_mux = hit_torch ? torch_q : hit_flash ? flash_q : hit_dur ? dur_q : hit_cfg1 ? cfg1_q :
        hit_cfg2 ? cfg2_q : hit_gpio ? gpio_q : hit_fault ? fault_q : hit_stat ? status : 8'h00;

    // Mode requests from the two enable fields
    wire [1:0] tmode = torch_q[`LFF_MODE_HI:`LFF_MODE_LO];
    wire [1:0] fmode = flash_q[`LFF_MODE_HI:`LFF_MODE_LO];
    wire reg_flash = tmode == 2'b11 || fmode == 2'b11;
    wire reg_torch = tmode == 2'b10 || fmode == 2'b10;
    wire ind_req = tmode == 2'b01 || fmode == 2'b01;
    wire hw_torch = cfg1_q[`LFF_CFG1_HWTORCH];
    wire therm_mode = cfg1_q[`LFF_CFG1_THERM_SEL];
    wire pin_end_sel = flash_q[`LFF_PIN_END_BIT];

    // Pin edges and second sync assertion
    wire strobe_rise = strobe_s && !strobe_prev_q;
    wire sync1_rise = sync1_s && !sync1_prev_q;
    wire tx2_act = cfg1_q[`LFF_CFG1_SYNC2_SEL] && (sync2_s == cfg1_q[`LFF_CFG1_SYNC2_POL]);
    wire tx2_rise = tx2_act && !tx2_prev_q;

    // ======================================================================
    // Timeout timebase
    wire in_flash = state_q == lff_pkg::LFF_FLASH;
    // Prescaler restarts at each flash
    wire tick = presc_q == TW'(TICK_CYCLES - 1);
    wire expire = in_flash && tick && ticks_q == dur_q[`LFF_DUR_HI:`LFF_DUR_LO];
    wire flash_start = (strobe_rise || reg_flash) && !in_flash && state_q != lff_pkg::LFF_AET_TORCH;
    wire restart_to = in_flash && pin_flash_q && !pin_end_sel && strobe_rise;
    wire aet_go = strobe_rise && cfg2_q[`LFF_CFG2_AET] && !hw_torch && sync1_s;

    // Flash termination
    wire pin_low_end = pin_flash_q && !pin_end_sel && !strobe_s;
    wire reg_off_end = !pin_flash_q && !reg_flash;
    wire flash_end = (in_flash && (expire || pin_low_end || reg_off_end)) ||
        (state_q == lff_pkg::LFF_AET_TORCH && (pin_low_end || reg_off_end));

    // Thermal deglitch
    wire degl_done = degl_q == DW'(DEGLITCH_CYCLES - 1);
    wire therm_set = therm_mode && trip_s && degl_done;

    // State transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            lff_pkg::LFF_OFF, lff_pkg::LFF_TORCH: begin
                if (aet_go) begin
                    state_d = lff_pkg::LFF_AET_TORCH;
                end else if (flash_start) begin
                    state_d = lff_pkg::LFF_FLASH;
                end else if (reg_torch || (hw_torch && sync1_s)) begin
                    state_d = lff_pkg::LFF_TORCH;
                end else begin
                    state_d = lff_pkg::LFF_OFF;
                end
            end
            lff_pkg::LFF_FLASH, lff_pkg::LFF_AET_TORCH: begin
                if (flash_end) begin
                    state_d = lff_pkg::LFF_OFF;
                end
            end
            default: state_d = lff_pkg::LFF_OFF;
        endcase
    end

    // Register writes, hardware clears; a host write in the same cycle wins
    always_comb begin
        torch_d = torch_q;
        flash_d = flash_q;
        cfg1_d = cfg1_q;
        if (flash_end) begin
            torch_d[`LFF_MODE_HI:`LFF_MODE_LO] = 2'b00;
            flash_d[`LFF_MODE_HI:`LFF_MODE_LO] = 2'b00;
            if (hwt_at_start_q) begin
                cfg1_d[`LFF_CFG1_HWTORCH] = 1'b0;
            end
        end
        if (wr && hit_torch) begin
            torch_d = PWDATA[7:0];
        end
        if (wr && hit_flash) begin
            flash_d = PWDATA[7:0];
        end
        if (wr && hit_cfg1) begin
            cfg1_d = PWDATA[7:0];
        end
    end

    // Fault flags: reported bits clear on read, new events win
    always_comb begin
        fault_d = fault_q;
        if (fault_rd) begin
            fault_d = fault_q & ~prdata_q[7:0];
        end
        if (flash_start) begin
            fault_d[`LFF_FLT_TIMEOUT] = 1'b0;
        end
        if (expire) begin
            fault_d[`LFF_FLT_TIMEOUT] = 1'b1;
        end
        if (sync1_rise && !hw_torch) begin
            fault_d[`LFF_FLT_SYNC1] = 1'b1;
        end
        if (tx2_rise) begin
            fault_d[`LFF_FLT_SYNC2] = 1'b1;
        end
        if (therm_set) begin
            fault_d[`LFF_FLT_THERM] = 1'b1;
        end
    end

    // ======================================================================
    // Configuration and bus registers
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            torch_q <= `LFF_RST_TORCH_LVL;
            flash_q <= `LFF_RST_FLASH_LVL;
            dur_q <= `LFF_RST_FLASH_DUR;
            cfg1_q <= `LFF_RST_CFG1;
            cfg2_q <= `LFF_RST_CFG2;
            gpio_q <= `LFF_RST_GPIO;
            fault_q <= 8'h00;
            prdata_q <= 32'h00000000;
        end else begin
            torch_q <= torch_d;
            flash_q <= flash_d;
            cfg1_q <= cfg1_d;
            fault_q <= fault_d;
            dur_q <= (wr && hit_dur) ? PWDATA[7:0] : dur_q;
            cfg2_q <= (wr && hit_cfg2) ? PWDATA[7:0] : cfg2_q;
            gpio_q <= (wr && hit_gpio) ? PWDATA[7:0] : gpio_q;
            prdata_q <= setup ? {24'h000000, rd_mux} : prdata_q;
        end
    end

    // ======================================================================
    // Mode state, timeout counter, edge history
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state_q <= lff_pkg::LFF_OFF;
            strobe_prev_q <= 1'b0;
            sync1_prev_q <= 1'b0;
            tx2_prev_q <= 1'b0;
            pin_flash_q <= 1'b0;
            hwt_at_start_q <= 1'b0;
            presc_q <= '0;
            ticks_q <= 5'h00;
        end else begin
            state_q <= state_d;
            strobe_prev_q <= strobe_s;
            sync1_prev_q <= sync1_s;
            tx2_prev_q <= tx2_act;
            if (state_d != state_q && state_d != lff_pkg::LFF_OFF && state_d != lff_pkg::LFF_TORCH) begin
                pin_flash_q <= strobe_rise;
                hwt_at_start_q <= hw_torch && state_q == lff_pkg::LFF_TORCH;
            end
            if (!in_flash || restart_to) begin
                presc_q <= '0;
                ticks_q <= 5'h00;
            end else begin
                presc_q <= tick ? '0 : presc_q + 1'b1;
                ticks_q <= tick ? ticks_q + 5'h01 : ticks_q;
            end
        end
    end

    // ======================================================================
    // Second sync shutdown latch and thermal response
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            sd2_q <= 1'b0;
            therm_hold_q <= 1'b0;
            therm_pin_q <= 1'b0;
            degl_q <= '0;
        end else begin
            if (in_flash && tx2_act && cfg2_q[`LFF_CFG2_SYNC2_SD]) begin
                sd2_q <= 1'b1;
            end else if (fault_rd) begin
                sd2_q <= 1'b0;
            end
            // Counts only with flag clear
            degl_q <= (therm_mode && trip_s && !fault_q[`LFF_FLT_THERM] && !degl_done) ? degl_q + 1'b1 : '0;
            if (therm_set) begin
                therm_hold_q <= 1'b1;
            end else if (!fault_q[`LFF_FLT_THERM] && !trip_s) begin
                therm_hold_q <= 1'b0;
            end
            if (therm_set) begin
                therm_pin_q <= 1'b1;
            end else if (fault_rd) begin
                therm_pin_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Current target selection
    wire therm_sd = therm_hold_q && cfg2_q[`LFF_CFG2_THERM_SD];
    wire tx1_torch = !hw_torch && sync1_s;
    wire to_torch = tx1_torch || (tx2_act && !cfg2_q[`LFF_CFG2_SYNC2_SD]) || therm_hold_q;
    wire flash_off = sd2_q || therm_sd;
    wire torch_state = state_q == lff_pkg::LFF_TORCH || state_q == lff_pkg::LFF_AET_TORCH;
    wire drive_on = (in_flash && !flash_off) || (torch_state && !therm_sd);
    wire drive_flash = in_flash && !to_torch;
    wire [3:0] torch_lvl = {1'b0, torch_q[`LFF_TORCH_LVL_HI:`LFF_TORCH_LVL_LO]};
    wire [3:0] flash_lvl = flash_q[`LFF_FLASH_LVL_HI:`LFF_FLASH_LVL_LO];
    lff_pkg::lff_drive_s target;
    assign target = '{on: drive_on, flash_scale: drive_flash, level: drive_flash ? flash_lvl : torch_lvl};

    // Stepped ramp shared by both main sources
    lff_pkg::lff_drive_s ramp_out;
    lff_ramp #(.STEP_CYCLES(RAMP_CYCLES)) u_ramp (
        .clk(CLOCK),
        .rst(RESET),
        .target(target),
        .cur(ramp_out)
    );

    // ======================================================================
    // Outputs
    wire gp2_out = gpio_q[`LFF_GPIO_SEL] && gpio_q[`LFF_GPIO_DIR_OUT];
    wire gp2_therm = gpio_q[`LFF_GPIO_THERM_EXP] && therm_mode;
    wire gp2_pull = gp2_out && (gp2_therm ? therm_pin_q : !gpio_q[`LFF_GPIO_DATA]);
    assign GENERAL_IO_TWO_OUT = 1'b0;
    assign GENERAL_IO_TWO_OE_N = !gp2_pull;
    // One word feeds both sources
    assign MAIN_CURRENT_SOURCE_A = ramp_out;
    assign MAIN_CURRENT_SOURCE_B = ramp_out;
    assign INDICATOR_DRIVER = '{on: ind_req && !therm_mode, level: torch_q[`LFF_IND_LVL_HI:`LFF_IND_LVL_LO]};
    assign VOLTAGE_OUTPUT_FORCE = torch_q[`LFF_VOUT_BIT] || flash_q[`LFF_VOUT_BIT] ||
        (!cfg1_q[`LFF_CFG1_SYNC2_SEL] && sync2_s);
    assign FLASH_ACTIVE = in_flash;
    assign PRDATA = prdata_q;
    assign PREADY = 1'b1;
    assign PSLVERR = access && !hit;
endmodule : lff_top

/* lff_top_checker.sv */
// Port assertions for the flash and torch mode controller.
// Assumes binding to lff_top, with its parameters handed on.
`timescale 1ns/1ns
module lff_top_checker #(
    parameter int TICK_CYCLES = 50,
    parameter int RAMP_CYCLES = 4
) (
    input wire logic CLOCK, // Core clock
    input wire logic RESET, // Async reset
    input wire logic [7:0] PADDR, // APB address
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access
    input wire logic PWRITE, // APB direction
    input wire logic PSLVERR, // APB error
    input wire logic STROBE, // Trigger pin
    input wire logic GENERAL_IO_TWO_OUT, // Pin value
    input lff_pkg::lff_drive_s MAIN_CURRENT_SOURCE_A, // Source A
    input lff_pkg::lff_drive_s MAIN_CURRENT_SOURCE_B, // Source B
    input wire logic FLASH_ACTIVE // Flash state
);
    // ==========================================================
    // Step hold and flash length counters
    logic [3:0] lvl_q;
    logic [7:0] hold_q;
    logic [31:0] fl_q;
    logic stb_q;
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            lvl_q <= 4'h0;
            hold_q <= 8'h00;
            fl_q <= 32'h0;
            stb_q <= 1'b0;
        end else begin
            lvl_q <= MAIN_CURRENT_SOURCE_A.level;
            hold_q <= (MAIN_CURRENT_SOURCE_A.level != lvl_q) ? 8'h00 : hold_q + {7'h0, hold_q != 8'hFF};
            fl_q <= (!FLASH_ACTIVE || (STROBE && !stb_q) || (PSEL && PWRITE)) ? 32'h0 : fl_q + 32'h1;
            stb_q <= STROBE;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    a_src_pair: assert property (MAIN_CURRENT_SOURCE_A == MAIN_CURRENT_SOURCE_B)
        else $error("source drives differ");
    a_flash_off: assert property ($fell(FLASH_ACTIVE) |-> ##[0:2] !MAIN_CURRENT_SOURCE_A.on)
        else $error("sources on after flash end");
    a_ramp_start: assert property ($rose(FLASH_ACTIVE) |-> ##[0:1] (MAIN_CURRENT_SOURCE_A.level == 4'h0))
        else $error("flash ramp not from zero");
    a_ramp_step: assert property ((MAIN_CURRENT_SOURCE_A.level > lvl_q) |-> (MAIN_CURRENT_SOURCE_A.level == lvl_q + 4'h1))
        else $error("ramp skipped a level");
    a_ramp_hold: assert property ((MAIN_CURRENT_SOURCE_A.level > lvl_q) |-> (hold_q >= RAMP_CYCLES - 1))
        else $error("ramp step too short");
    a_timeout_len: assert property (fl_q <= 32 * TICK_CYCLES + 16)
        else $error("flash outlived longest timeout");
    a_io_two_low: assert property (GENERAL_IO_TWO_OUT == 1'b0)
        else $error("multi pin drives high");
    a_slverr_map: assert property ((PSEL && PENABLE && PADDR > 8'h1C) |-> PSLVERR)
        else $error("unmapped access not refused");
    c_flash: cover property ($rose(FLASH_ACTIVE));
    c_torch: cover property (MAIN_CURRENT_SOURCE_A.on && !FLASH_ACTIVE);
    c_refuse: cover property (PSLVERR);
endmodule : lff_top_checker

bind lff_top lff_top_checker #(.TICK_CYCLES(TICK_CYCLES), .RAMP_CYCLES(RAMP_CYCLES)) chk_i (.CLOCK, .RESET, .PADDR,
    .PSEL, .PENABLE, .PWRITE, .PSLVERR, .STROBE, .GENERAL_IO_TWO_OUT, .MAIN_CURRENT_SOURCE_A,
    .MAIN_CURRENT_SOURCE_B, .FLASH_ACTIVE);

/* lff_host_pins.sv */
// Host pin model: trigger, sync one, multi pin and sense levels.
// Assumes the bench names the wanted levels; they land on clock edges.
`timescale 1ns/1ns
module lff_host_pins (
    input wire logic clk, // Core clock
    input wire logic [3:0] want, // Wanted levels
    output logic [3:0] pins = 4'h0 // Driven levels
);
    // ==========================================================
    // Pins change just after an edge, never mid-cycle
    always @(posedge clk) begin
        pins <= want;
    end
endmodule : lff_host_pins

/* tb_top.sv */
// Self-checking bench for the flash and torch mode controller.
// Assumes lff_top, its bound checker and the host pin model.
`timescale 1ns/1ns
module tb_top;
    // ==========================================================
    // Signals
    logic CLOCK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] PADDR = 8'h00;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, OUT2, OE2_N, FA, VOUT, err;
    logic [3:0] pin_cmd = 4'h0, pins;
    lff_pkg::lff_drive_s SRC_A, SRC_B;
    lff_pkg::lff_ind_s IND;
    int failures = 0, samples_checked = 0, n;
    initial forever #5 CLOCK = ~CLOCK;
    lff_host_pins host (.clk(CLOCK), .want(pin_cmd), .pins(pins));
    lff_top #(.TICK_CYCLES(50), .DEGLITCH_CYCLES(20), .RAMP_CYCLES(4)) dut (.CLOCK(CLOCK), .RESET(RESET),
        .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .STROBE(pins[0]), .RADIO_SYNC_INPUT_ONE(pins[1]),
        .GENERAL_IO_TWO_IN(OE2_N ? pins[2] : 1'b0), .GENERAL_IO_TWO_OUT(OUT2), .GENERAL_IO_TWO_OE_N(OE2_N),
        .THERMISTOR_SENSE_TRIP(pins[3]), .MAIN_CURRENT_SOURCE_A(SRC_A), .MAIN_CURRENT_SOURCE_B(SRC_B),
        .INDICATOR_DRIVER(IND), .VOLTAGE_OUTPUT_FORCE(VOUT), .FLASH_ACTIVE(FA));
    // ==========================================================
    // Shared tasks
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge CLOCK);
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= d;
        PSEL <= 1'b1;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLOCK);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        if (PREADY !== 1'b1) begin
            chk(0, 1);
            report_and_stop();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task pin(input logic [3:0] v);
        @(posedge CLOCK);
        pin_cmd <= v;
    endtask : pin
    task wait_fa(input logic lvl, input int lim);
        n = 0;
        while (FA !== lvl && n < lim) begin
            @(negedge CLOCK);
            n++;
        end
        if (FA !== lvl) begin
            chk(0, 1);
            report_and_stop();
        end
    endtask : wait_fa
    // ==========================================================
    // Scenarios
    task t_regs;
        apb(0, 8'h08, 0);
        chk(rd, 32'h0F);
        apb(1, 8'h20, 32'hFF);
        chk(err, 1);
        apb(0, 8'h20, 0);
        chk(rd, 0);
        pin(4'h4);
        repeat (8) @(negedge CLOCK);
        chk(VOUT, 1);
        pin(4'h0);
    endtask : t_regs
    task t_torch;
        apb(1, 8'h00, 32'h2A);
        repeat (40) @(negedge CLOCK);
        chk(SRC_A, 32'h25);
        apb(1, 8'h00, 32'hC1);
        repeat (2) @(negedge CLOCK);
        chk(IND, 32'h7);
        apb(1, 8'h00, 0);
    endtask : t_torch
    task t_reg_flash;
        apb(1, 8'h08, 0);
        apb(1, 8'h04, 32'h1B);
        wait_fa(1, 20);
        repeat (30) @(negedge CLOCK);
        chk(SRC_A, 32'h33);
        wait_fa(0, 60);
        chk((30 + n) inside {[48:53]}, 1);
        repeat (3) @(negedge CLOCK);
        chk(SRC_A.on, 0);
        apb(0, 8'h04, 0);
        chk(rd, 32'h18);
        apb(0, 8'h00, 0);
        chk(rd, 0);
    endtask : t_reg_flash
    task t_pin_flash;
        apb(1, 8'h08, 32'h01);
        pin(4'h1);
        wait_fa(1, 20);
        repeat (20) @(negedge CLOCK);
        pin(4'h0);
        wait_fa(0, 15);
        repeat (3) @(negedge CLOCK);
        chk(SRC_A.on, 0);
        apb(1, 8'h04, 32'h98);
        pin(4'h1);
        wait_fa(1, 20);
        pin(4'h0);
        repeat (30) @(negedge CLOCK);
        chk(FA, 1);
        wait_fa(0, 150);
        apb(0, 8'h04, 0);
        chk(rd, 32'h98);
    endtask : t_pin_flash
    task t_therm;
        apb(1, 8'h0C, 32'h08);
        apb(1, 8'h14, 32'h58);
        pin(4'h8);
        repeat (40) @(negedge CLOCK);
        chk(OE2_N, 0);
        pin(4'h0);
        apb(0, 8'h18, 0);
        chk(rd[5], 1);
        @(negedge CLOCK);
        chk(OE2_N, 1);
    endtask : t_therm
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge CLOCK);
        RESET <= 1'b0;
        t_regs;
        t_torch;
        t_reg_flash;
        t_pin_flash;
        t_therm;
        report_and_stop;
    end
endmodule : tb_top
